// ==== hw/ccm_pkg.sv ====
package ccm_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] CCM_OFS_CONTROL = 8'h00; // capcomp_control, mode in low nibble
	localparam logic [7:0] CCM_OFS_COMPARE = 8'h04; // compare value
	localparam logic [7:0] CCM_OFS_CAPTURE = 8'h08; // captured timer value, read only
	localparam logic [7:0] CCM_OFS_STATUS  = 8'h0C; // event flag, out level, write 1 clears flag
	localparam logic [7:0] CCM_OFS_PWMDUTY = 8'h10; // pwm duty value

	// field layout
	localparam int CCM_MODE_LSB  = 0;
	localparam int CCM_MODE_W    = 4;
	localparam int CCM_CTRL_W    = 8;
	localparam int CCM_TMR_W     = 16;
	localparam int CCM_PWM_W     = 8;
	localparam int CCM_FLAG_BIT  = 0;
	localparam int CCM_OUT_BIT   = 1;

	// reset values
	localparam logic [7:0]  CCM_CTRL_RST = 8'h00;
	localparam logic [15:0] CCM_TMR_RST  = 16'h0000;
	localparam logic [7:0]  CCM_PWM_RST  = 8'h00;

	// prescale counts for capture modes
	localparam logic [3:0] CCM_PRE4_LAST  = 4'h3;
	localparam logic [3:0] CCM_PRE16_LAST = 4'hF;

	// bus response codes
	localparam logic [1:0] CCM_RESP_OKAY   = 2'b00;
	localparam logic [1:0] CCM_RESP_SLVERR = 2'b10;

	// mode codes
	localparam logic [3:0] CCM_M_OFF      = 4'h0;
	localparam logic [3:0] CCM_M_TOG_CLR  = 4'h1;
	localparam logic [3:0] CCM_M_TOG      = 4'h2;
	localparam logic [3:0] CCM_M_CAP_ANY  = 4'h3;
	localparam logic [3:0] CCM_M_CAP_FALL = 4'h4;
	localparam logic [3:0] CCM_M_CAP_RISE = 4'h5;
	localparam logic [3:0] CCM_M_CAP_R4   = 4'h6;
	localparam logic [3:0] CCM_M_CAP_R16  = 4'h7;
	localparam logic [3:0] CCM_M_SET      = 4'h8;
	localparam logic [3:0] CCM_M_CLR      = 4'h9;
	localparam logic [3:0] CCM_M_PULSE    = 4'hA;
	localparam logic [3:0] CCM_M_PULSE_CL = 4'hB;
	localparam logic [3:0] CCM_M_PWM      = 4'hF;

	// read channel state
	typedef enum logic [0:0] {CCM_RD_IDLE, CCM_RD_RESP} ccm_rd_st_t;
	// write channel state
	typedef enum logic [1:0] {CCM_WR_IDLE, CCM_WR_GOT_A, CCM_WR_GOT_D, CCM_WR_RESP} ccm_wr_st_t;

	// axi4-lite write request from master
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
	} ccm_axi_wreq_t;

	// axi4-lite read request from master
	typedef struct packed {
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} ccm_axi_rreq_t;

	// whole state of the unit
	typedef struct packed {
		ccm_wr_st_t  wr_st;
		logic [7:0]  wr_addr;
		logic [31:0] wr_data;
		logic [3:0]  wr_strb;
		logic [1:0]  bresp;
		ccm_rd_st_t  rd_st;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  ctrl;
		logic [15:0] cmp;
		logic [15:0] cap;
		logic [7:0]  duty;
		logic [15:0] ref_tmr;
		logic [7:0]  pwm_tmr;
		logic [3:0]  pre_cnt;
		logic        pin_q;
		logic        out;
		logic        flag;
		logic        adc_trig;
	} ccm_state_t;

endpackage

// ==== hw/ccm_unit.sv ====
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - mode zero disables all and resets unit
// - mode 0011 captures on every input edge
// - mode 0100 captures on falling edges only
// - mode 0101 captures on rising edges only
// - mode 0110 captures every fourth rising edge
// - mode 0111 captures every sixteenth rising edge
// - mode 0010 toggles output on match
// - mode 0001 toggles output, clears timer
// - mode 1000 sets output on match
// - mode 1001 clears output on match
// - mode 1010 pulses output on match
// - mode 1011 pulses output, clears timer
// - mode 1111 is pwm on period timer
// - every mode event sets the event flag
// - events trigger conversion when unit selected
module ccm_unit
	import ccm_pkg::*;
(
	input  wire logic          clk_sys_i,   // 10 MHz system clock
	input  wire logic          reset_n_i,   // async reset, active low
	input  wire ccm_axi_wreq_t axi_wreq_i,  // write address, data, bready
	input  wire ccm_axi_rreq_t axi_rreq_i,  // read address, rready
	output logic               awready_o,   // write address taken
	output logic               wready_o,    // write data taken
	output logic               bvalid_o,    // write response valid
	output logic [1:0]         bresp_o,     // write response code
	output logic               arready_o,   // read address taken
	output logic               rvalid_o,    // read data valid
	output logic [31:0]        rdata_o,     // read data
	output logic [1:0]         rresp_o,     // read response code
	input  wire logic          cc_pin_i,    // capcomp_unit input pin
	input  wire logic          adc_sel_i,   // this unit is the conversion trigger source
	output logic               cc_pin_o,    // capcomp_unit output pin
	output logic               event_flag_o,// capcomp_event_flag
	output logic               adc_trig_o   // one-cycle conversion start
);

	ccm_state_t st_ff;   // registered state
	ccm_state_t nxt_st;  // next state

	logic [3:0] mode;        // current mode field
	logic       rise;        // rising input edge
	logic       fall;        // falling input edge
	logic       cap_ev;      // capture happens this cycle
	logic       cmp_match;   // reference timer equals compare
	logic       cmp_ev;      // compare event this cycle
	logic       pwm_ev;      // pwm period rollover
	logic       any_ev;      // any mode event
	logic       clr_ref;     // clear reference timer on match
	logic       is_cmp;      // mode is a compare mode
	logic [7:0] a_wr;        // effective write address
	logic [31:0] w_dat;      // effective write data
	logic [3:0]  w_stb;      // effective write strobes
	logic        do_wr;      // write commits this cycle
	logic        flag_clr;   // software clears the flag
	logic [31:0] rd_val;     // decoded read value
	logic        rd_ok;      // read address mapped
	logic        wr_ok;      // write address mapped

	// edge detection and event decode
	always_comb begin
		mode      = st_ff.ctrl[CCM_MODE_LSB +: CCM_MODE_W];
		rise      = cc_pin_i & ~st_ff.pin_q;
		fall      = ~cc_pin_i & st_ff.pin_q;
		cmp_match = (st_ff.ref_tmr == st_ff.cmp);
		is_cmp    = 1'b0;
		clr_ref   = 1'b0;
		cap_ev    = 1'b0;
		pwm_ev    = 1'b0;
		case (mode)
			CCM_M_CAP_ANY:  cap_ev = rise | fall;
			CCM_M_CAP_FALL: cap_ev = fall;
			CCM_M_CAP_RISE: cap_ev = rise;
			CCM_M_CAP_R4:   cap_ev = rise & (st_ff.pre_cnt[1:0] == CCM_PRE4_LAST[1:0]);
			CCM_M_CAP_R16:  cap_ev = rise & (st_ff.pre_cnt == CCM_PRE16_LAST);
			CCM_M_TOG, CCM_M_SET, CCM_M_CLR, CCM_M_PULSE: begin
				is_cmp = 1'b1;
			end
			CCM_M_TOG_CLR, CCM_M_PULSE_CL: begin
				is_cmp  = 1'b1;
				clr_ref = 1'b1;
			end
			CCM_M_PWM: pwm_ev = (st_ff.pwm_tmr == 8'hFF);
			default: begin
				// off and reserved codes: no activity
				cap_ev = 1'b0;
			end
		endcase
		cmp_ev = is_cmp & cmp_match;
		any_ev = cap_ev | cmp_ev | pwm_ev;
	end

	// axi write address and data may arrive in either order
	always_comb begin
		a_wr  = (st_ff.wr_st == CCM_WR_GOT_A) ? st_ff.wr_addr : axi_wreq_i.awaddr;
		w_dat = (st_ff.wr_st == CCM_WR_GOT_D) ? st_ff.wr_data : axi_wreq_i.wdata;
		w_stb = (st_ff.wr_st == CCM_WR_GOT_D) ? st_ff.wr_strb : axi_wreq_i.wstrb;
		case (st_ff.wr_st)
			CCM_WR_IDLE:  do_wr = axi_wreq_i.awvalid & axi_wreq_i.wvalid;
			CCM_WR_GOT_A: do_wr = axi_wreq_i.wvalid;
			CCM_WR_GOT_D: do_wr = axi_wreq_i.awvalid;
			default:      do_wr = 1'b0;
		endcase
		wr_ok = (a_wr == CCM_OFS_CONTROL) || (a_wr == CCM_OFS_COMPARE) ||
			(a_wr == CCM_OFS_STATUS) || (a_wr == CCM_OFS_PWMDUTY);
		flag_clr = do_wr && (a_wr == CCM_OFS_STATUS) && w_stb[0] && w_dat[CCM_FLAG_BIT];
	end

	// read decode
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (axi_rreq_i.araddr)
			CCM_OFS_CONTROL: rd_val[CCM_CTRL_W-1:0] = st_ff.ctrl;
			CCM_OFS_COMPARE: rd_val[CCM_TMR_W-1:0]  = st_ff.cmp;
			CCM_OFS_CAPTURE: rd_val[CCM_TMR_W-1:0]  = st_ff.cap;
			CCM_OFS_STATUS: begin
				rd_val[CCM_FLAG_BIT] = st_ff.flag;
				rd_val[CCM_OUT_BIT]  = st_ff.out;
			end
			CCM_OFS_PWMDUTY: rd_val[CCM_PWM_W-1:0]  = st_ff.duty;
			default:         rd_ok = 1'b0; // unmapped answers slverr
		endcase
	end

	// next state of the whole unit
	always_comb begin
		nxt_st          = st_ff;
		nxt_st.pin_q    = cc_pin_i;
		nxt_st.adc_trig = 1'b0;

		// write channel
		case (st_ff.wr_st)
			CCM_WR_IDLE: begin
				if (do_wr) begin
					nxt_st.wr_st = CCM_WR_RESP;
				end else if (axi_wreq_i.awvalid) begin
					nxt_st.wr_st   = CCM_WR_GOT_A;
					nxt_st.wr_addr = axi_wreq_i.awaddr;
				end else if (axi_wreq_i.wvalid) begin
					nxt_st.wr_st   = CCM_WR_GOT_D;
					nxt_st.wr_data = axi_wreq_i.wdata;
					nxt_st.wr_strb = axi_wreq_i.wstrb;
				end
			end
			CCM_WR_GOT_A, CCM_WR_GOT_D: begin
				if (do_wr) begin
					nxt_st.wr_st = CCM_WR_RESP;
				end
			end
			CCM_WR_RESP: begin
				if (axi_wreq_i.bready) begin
					nxt_st.wr_st = CCM_WR_IDLE;
				end
			end
			default: nxt_st.wr_st = CCM_WR_IDLE;
		endcase
		if (do_wr) begin
			nxt_st.bresp = wr_ok ? CCM_RESP_OKAY : CCM_RESP_SLVERR;
			if (w_stb[0]) begin
				case (a_wr)
					CCM_OFS_CONTROL: nxt_st.ctrl     = w_dat[7:0];
					CCM_OFS_COMPARE: nxt_st.cmp[7:0] = w_dat[7:0];
					CCM_OFS_PWMDUTY: nxt_st.duty     = w_dat[7:0];
					default:         nxt_st.ctrl     = nxt_st.ctrl;
				endcase
			end
			if (w_stb[1] && a_wr == CCM_OFS_COMPARE) begin
				nxt_st.cmp[15:8] = w_dat[15:8];
			end
		end

		// read channel
		case (st_ff.rd_st)
			CCM_RD_IDLE: begin
				if (axi_rreq_i.arvalid) begin
					nxt_st.rd_st = CCM_RD_RESP;
					nxt_st.rdata = rd_val;
					nxt_st.rresp = rd_ok ? CCM_RESP_OKAY : CCM_RESP_SLVERR;
				end
			end
			CCM_RD_RESP: begin
				if (axi_rreq_i.rready) begin
					nxt_st.rd_st = CCM_RD_IDLE;
				end
			end
			default: nxt_st.rd_st = CCM_RD_IDLE;
		endcase

		// timers run in every mode but off, which holds them at zero
		nxt_st.ref_tmr = st_ff.ref_tmr + 16'h0001;
		if (cmp_ev && clr_ref) begin
			nxt_st.ref_tmr = CCM_TMR_RST;
		end
		nxt_st.pwm_tmr = st_ff.pwm_tmr + 8'h01;

		// prescaler counts rising edges only in prescaled capture modes
		if ((mode == CCM_M_CAP_R4 || mode == CCM_M_CAP_R16) && rise) begin
			nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
		end

		// capture copies the reference timer
		if (cap_ev) begin
			nxt_st.cap = st_ff.ref_tmr;
		end

		// output actions
		case (mode)
			CCM_M_TOG, CCM_M_TOG_CLR: if (cmp_ev) nxt_st.out = ~st_ff.out;
			CCM_M_SET:                if (cmp_ev) nxt_st.out = 1'b1;
			CCM_M_CLR:                if (cmp_ev) nxt_st.out = 1'b0;
			CCM_M_PULSE, CCM_M_PULSE_CL: nxt_st.out = cmp_ev;
			// high while period timer below duty
			CCM_M_PWM: nxt_st.out = (nxt_st.pwm_tmr < st_ff.duty);
			default:   nxt_st.out = st_ff.out;
		endcase

		// flag: set wins over a clear in the same cycle
		if (flag_clr) begin
			nxt_st.flag = 1'b0;
		end
		if (any_ev) begin
			nxt_st.flag = 1'b1;
		end
		nxt_st.adc_trig = any_ev & adc_sel_i;

		// mode off holds the unit in reset; compare and duty keep their values
		// so software can set them up before choosing a mode
		if (nxt_st.ctrl[CCM_MODE_LSB +: CCM_MODE_W] == CCM_M_OFF) begin
			nxt_st.ref_tmr  = CCM_TMR_RST;
			nxt_st.cap      = CCM_TMR_RST; // stale capture would look like a new one
			nxt_st.flag     = 1'b0;        // a unit held off reports no event
			nxt_st.pwm_tmr  = CCM_PWM_RST;
			nxt_st.pre_cnt  = 4'h0;
			nxt_st.out      = 1'b0;
			nxt_st.adc_trig = 1'b0;
		end
		// leaving a prescaled mode drops the partial count
		if (nxt_st.ctrl[CCM_MODE_LSB +: CCM_MODE_W] != mode) begin
			nxt_st.pre_cnt = 4'h0;
		end
	end

	// single state register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flip-flops
	always_comb begin
		awready_o    = (st_ff.wr_st == CCM_WR_IDLE) || (st_ff.wr_st == CCM_WR_GOT_D);
		wready_o     = (st_ff.wr_st == CCM_WR_IDLE) || (st_ff.wr_st == CCM_WR_GOT_A);
		bvalid_o     = (st_ff.wr_st == CCM_WR_RESP);
		bresp_o      = st_ff.bresp;
		arready_o    = (st_ff.rd_st == CCM_RD_IDLE);
		rvalid_o     = (st_ff.rd_st == CCM_RD_RESP);
		rdata_o      = st_ff.rdata;
		rresp_o      = st_ff.rresp;
		cc_pin_o     = st_ff.out;
		event_flag_o = st_ff.flag;
		adc_trig_o   = st_ff.adc_trig;
	end

endmodule

// ==== bench/ccm_unit_asserts.sv ====
`timescale 1ns/1ps
// watches the bus handshakes and the event outputs of the unit
module ccm_unit_asserts
	import ccm_pkg::*;
(
	input  wire logic          clk_sys_i,
	input  wire logic          reset_n_i,
	input  wire ccm_axi_wreq_t axi_wreq_i,
	input  wire ccm_axi_rreq_t axi_rreq_i,
	input  wire logic          awready_o,
	input  wire logic          wready_o,
	input  wire logic          bvalid_o,
	input  wire logic          arready_o,
	input  wire logic          rvalid_o,
	input  wire logic [31:0]   rdata_o,
	input  wire logic          adc_sel_i,
	input  wire logic          event_flag_o,
	input  wire logic          adc_trig_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// address and data taken at one edge
	sequence s_wr_taken;
		axi_wreq_i.awvalid && awready_o && axi_wreq_i.wvalid && wready_o;
	endsequence
	sequence s_rd_taken;
		axi_rreq_i.arvalid && arready_o;
	endsequence
	a_wr_answer: assert property (s_wr_taken |=> bvalid_o)
		else $error("write response missing");
	a_b_stands: assert property (bvalid_o && !axi_wreq_i.bready |=> bvalid_o)
		else $error("write response dropped early");
	a_aw_refused: assert property (bvalid_o |-> !awready_o)
		else $error("address taken while response pending");
	a_rd_answer: assert property (s_rd_taken |=> rvalid_o)
		else $error("read data missing");
	a_r_stands: assert property (rvalid_o && !axi_rreq_i.rready |=> rvalid_o && $stable(rdata_o))
		else $error("read data not held");
	a_ar_refused: assert property (rvalid_o |-> !arready_o)
		else $error("read address taken while data pending");
	a_trig_sel: assert property (adc_trig_o |-> $past(adc_sel_i))
		else $error("conversion start while unselected");
	a_trig_flag: assert property (adc_trig_o |-> event_flag_o)
		else $error("conversion start without event flag");
	a_flag_trig: assert property ($rose(event_flag_o) && $past(adc_sel_i) |-> adc_trig_o)
		else $error("event without conversion start");
endmodule
bind ccm_unit ccm_unit_asserts ccm_unit_asserts_i (.clk_sys_i, .reset_n_i, .axi_wreq_i,
	.axi_rreq_i, .awready_o, .wready_o, .bvalid_o, .arready_o, .rvalid_o, .rdata_o,
	.adc_sel_i, .event_flag_o, .adc_trig_o);

// ==== bench/ccm_pin_model.sv ====
`timescale 1ns/1ps
// far-side signal source: a burst of input edges, four clocks apart
module ccm_pin_model (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic       start_i,   // load a new burst
	input  wire logic [5:0] edges_i,   // edges in the burst
	output logic            pin_o      // drives the capture input
);
	logic [5:0] left_ff;  // edges still to make
	logic [1:0] phase_ff; // spacing so every edge is seen
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			left_ff  <= '0;
			phase_ff <= '0;
			pin_o    <= 1'b0;
		end else if (start_i) begin
			left_ff  <= edges_i;
			phase_ff <= '0;
		end else if (left_ff != 6'h0) begin
			phase_ff <= phase_ff + 2'd1;
			if (phase_ff == 2'd3) begin
				pin_o   <= ~pin_o;
				left_ff <= left_ff - 6'd1;
			end
		end
	end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
	import ccm_pkg::*;
	logic clk_sys_i = 0, reset_n_i = 0, adc_sel_i = 1, start = 0, pin, pin_q = 0;
	logic [5:0] edges = 0;
	ccm_axi_wreq_t wq = '0;
	ccm_axi_rreq_t rq = '0;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, cc_pin_o, event_flag_o, adc_trig_o;
	logic [1:0] bresp_o, rresp_o, r, b;
	logic [31:0] rdata_o, d;
	int bad_count = 0, checks_done = 0, cyc = 0, trig_n = 0, rise_n = 0, t, u;
	logic [3:0] md [14] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h2, 4'h1, 4'h8, 4'hA, 4'hB,
		4'hC, 4'hD, 4'hE, 4'hF};
	// negative entries mean at least that many
	int et [14] = '{32, 16, 16, 4, 1, 1, -5, 1, 1, -5, 0, 0, 0, -2};
	int er [14] = '{0, 0, 0, 0, 0, 1, -3, 1, 1, -5, 0, 0, 0, -2};
	always #50 clk_sys_i = ~clk_sys_i;
	ccm_unit ccm_unit_i (.clk_sys_i, .reset_n_i, .axi_wreq_i(wq), .axi_rreq_i(rq), .awready_o,
		.wready_o, .bvalid_o, .bresp_o, .arready_o, .rvalid_o, .rdata_o, .rresp_o,
		.cc_pin_i(pin), .adc_sel_i, .cc_pin_o, .event_flag_o, .adc_trig_o);
	ccm_pin_model ccm_pin_model_i (.clk_sys_i, .reset_n_i, .start_i(start), .edges_i(edges),
		.pin_o(pin));
	// event and output-rise counters, plus the hang limit
	always @(posedge clk_sys_i) begin
		cyc++;
		if (adc_trig_o === 1'b1) trig_n++;
		if (cc_pin_o === 1'b1 && pin_q !== 1'b1) rise_n++;
		pin_q <= cc_pin_o;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cnt(input int seen, input int exp);
		if (exp < 0) chk(seen >= -exp, 1);
		else chk(seen, exp);
	endtask
	task finish_test;
		$display("mismatches %0d of %0d checks", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// one write, each channel released when taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		wq <= '{1'b1, a, 1'b1, v, 4'hF, 1'b1};
		forever begin
			@(posedge clk_sys_i);
			if (awready_o) wq.awvalid <= 1'b0;
			if (wready_o) wq.wvalid <= 1'b0;
			if (bvalid_o) break;
		end
		b = bresp_o;
		wq.bready <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task rd(input logic [7:0] a);
		rq <= '{1'b1, a, 1'b1};
		forever begin
			@(posedge clk_sys_i);
			if (arready_o) rq.arvalid <= 1'b0;
			if (rvalid_o) break;
		end
		d = rdata_o;
		r = rresp_o;
		rq.rready <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task pins(input logic [5:0] n);
		edges <= n;
		start <= 1'b1;
		@(posedge clk_sys_i);
		start <= 1'b0;
	endtask
	// off first, then the mode, then a burst of edges
	task run(input logic [3:0] m, input int w);
		int t0, r0;
		wr(CCM_OFS_CONTROL, 0);
		wr(CCM_OFS_COMPARE, 20);
		wr(CCM_OFS_PWMDUTY, 20);
		t0 = trig_n;
		r0 = rise_n;
		wr(CCM_OFS_CONTROL, {28'h0, m});
		pins(32);
		repeat (w) @(posedge clk_sys_i);
		t = trig_n - t0;
		u = rise_n - r0;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(CCM_OFS_CONTROL);
		chk(d, 0);
		rd(8'h20);
		chk(r, CCM_RESP_SLVERR);
		chk(d, 0);
		wr(CCM_OFS_CAPTURE, 5);
		chk(b, CCM_RESP_SLVERR);
		for (int i = 0; i < 14; i++) begin
			run(md[i], (md[i] == 4'hF) ? 600 : 150);
			cnt(t, et[i]);
			cnt(u, er[i]);
		end
		run(4'h8, 150);
		chk(cc_pin_o, 1);
		wr(CCM_OFS_COMPARE, 400);
		chk(b, CCM_RESP_OKAY);
		rd(CCM_OFS_COMPARE);
		chk(d, 400);
		wr(CCM_OFS_CONTROL, 9);
		repeat (300) @(posedge clk_sys_i);
		chk(cc_pin_o, 0);
		wr(CCM_OFS_STATUS, 1);
		chk(event_flag_o, 0);
		wr(CCM_OFS_CONTROL, 5);
		pins(2);
		repeat (12) @(posedge clk_sys_i);
		rd(CCM_OFS_STATUS);
		chk(d[0], 1);
		chk(event_flag_o, 1);
		rd(CCM_OFS_CAPTURE);
		chk(d != 0, 1);
		wr(CCM_OFS_STATUS, 1);
		rd(CCM_OFS_STATUS);
		chk(d[0], 0);
		pins(2);
		repeat (12) @(posedge clk_sys_i);
		wr(CCM_OFS_CONTROL, 0);
		rd(CCM_OFS_STATUS);
		chk(d, 0);
		rd(CCM_OFS_CAPTURE);
		chk(d, 0);
		adc_sel_i <= 1'b0;
		run(4'h3, 150);
		chk(t, 0);
		chk(event_flag_o, 1);
		finish_test();
	end
endmodule
